//--- verilog/mscl_regs.vh
`ifndef MSCL_REGS_VH
`define MSCL_REGS_VH
// Register offsets (byte addresses, one aligned word each)
`define MSCL_OFS_CTRL 8'h00
`define MSCL_OFS_OWN_LEN 8'h04
`define MSCL_OFS_CHAIN_LEN 8'h08
`define MSCL_OFS_STATUS 8'h0C
`define MSCL_OFS_INT_STAT 8'h10
`define MSCL_OFS_INT_MASK 8'h14
`define MSCL_OFS_LAST_WORD 8'h18
// Control fields
`define MSCL_CTRL_CRC_EN 0
// Interrupt status / mask fields
`define MSCL_INT_DONE 0
`define MSCL_INT_CRC_ERR 1
`define MSCL_INT_MODE_ERR 2
`define MSCL_INT_PROG 3
`define MSCL_INT_WORD 4
`define MSCL_INT_W 5
// Status fields
`define MSCL_ST_STATE_LSB 0
`define MSCL_ST_MODE_LSB 4
`define MSCL_ST_PUD 7
`define MSCL_ST_RATE_LSB 8
// Reset values
`define MSCL_RST_CTRL 32'h0000_0001
`define MSCL_RST_OWN_LEN 32'h0000_0200
`define MSCL_RST_CHAIN_LEN 32'h0000_0000
`define MSCL_RST_INT_MASK 5'h00
// Timing
`define MSCL_SYS_PERIOD_NS 40
`define MSCL_PROG_MIN_NS 500
`define MSCL_CLEAR_CYCLES 64
// Configuration clock half periods in system cycles, slowest first
`define MSCL_HALF_SLOW 8'h10
`define MSCL_HALF_MID 8'h08
`define MSCL_HALF_FAST 8'h04
// CRC over the bitstream
`define MSCL_CRC_POLY 16'h1021
`define MSCL_CRC_INIT 16'hFFFF
`endif

//--- verilog/mscl_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for pins coming from outside the clock domain
module mscl_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire clk_sys_in, // System clock
   input wire rst_b_in, // Asynchronous reset, active low
   input wire [WIDTH-1:0] async_in, // Raw pin levels
   output wire [WIDTH-1:0] sync_out // Synchronised levels
);
   reg [WIDTH-1:0] meta_r; // First stage, read only by second stage
   reg [WIDTH-1:0] sync_r; // Second stage

   ////////////////////////////////////////////////////////////////////////
   // Two flops; reset constants only
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_r <= INIT;
         sync_r <= INIT;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;
endmodule // mscl_sync

//--- verilog/mscl_clkdiv.v
`timescale 1ns/1ps
// Configuration clock generator, stands in for the internal oscillator
module mscl_clkdiv (
   input wire clk_sys_in, // System clock
   input wire rst_b_in, // Asynchronous reset, active low
   input wire run_in, // Clock toggles while high; parks low while low
   input wire [7:0] half_in, // Half period in system cycles
   output reg gclk_out, // Divided clock level
   output reg rise_out, // One-cycle pulse on rising edge
   output reg fall_out // One-cycle pulse on falling edge
);
   reg [7:0] cnt_r; // Cycles elapsed in current half period

   ////////////////////////////////////////////////////////////////////////
   // Divider; a new half period length takes effect at once, within the current half period
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r <= 8'h00;
         gclk_out <= 1'b0;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end else if (!run_in) begin
         // Parked low so the memory sees no stray edge
         cnt_r <= 8'h00;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
         if (gclk_out) begin
            gclk_out <= 1'b0;
            fall_out <= 1'b1;
         end
      end else if (cnt_r >= half_in - 8'h01) begin
         cnt_r <= 8'h00;
         gclk_out <= ~gclk_out;
         rise_out <= ~gclk_out;
         fall_out <= gclk_out;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end
   end
endmodule // mscl_clkdiv

//--- verilog/mscl_loader.v
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "mscl_regs.vh"

// What this block does
// - Mode pins all zero selects master serial
// - Own divider drives configuration clock out
// - Capture one data bit per rising edge
// - Release mode and pull-up pins after done
// - Pull-up select low enables pull-ups until done
// - Actively drive serial output during configuration
// - Init low while clearing, release, sample mode
// - CRC error drives init low
// - Done low until successful finish
// - Program pulse of 500 ns restarts load
// - Forward chain data on falling clock edge
// - Start slowest; speed up if bitstream asks
module mscl_loader #(
   parameter CLEAR_CYCLES = `MSCL_CLEAR_CYCLES // Memory clearing duration
) (
   input wire clk_sys_in, // System clock, 25 MHz
   input wire rst_b_in, // Power-on reset, active low
   input wire [7:0] reg_addr_in, // Register byte address
   input wire [31:0] reg_wdata_in, // Register write data
   input wire reg_wr_in, // Write strobe
   input wire reg_rd_in, // Read strobe
   output reg [31:0] reg_rdata_out, // Read data, cycle after strobe
   output wire irq_out, // Level interrupt
   input wire [2:0] mode_select_in, // Boot-mode select pins
   input wire pullup_disable_select_in, // Pull-up disable select pin
   input wire program_request_n_in, // Program request, active low
   input wire init_n_in, // Init indicator pin level
   output wire init_n_out, // Init indicator drive value (always 0)
   output wire init_n_oe_out, // Init indicator pulled low while high
   input wire done_in, // Completion indicator pin level
   output wire done_out, // Completion drive value (always 0)
   output wire done_oe_out, // Completion pulled low while high
   output wire config_clock_out, // Configuration clock to memory
   input wire serial_data_in, // Serial configuration data from memory
   output reg serial_data_out, // Serial data to next chained device
   output wire serial_data_oe_out, // Serial output enable
   output wire user_pins_release_out, // Mode/pull-up pins become user I/O
   output wire pullup_enable_out, // User pin pull-ups active
   output reg [31:0] config_word_out, // Assembled configuration word
   output reg config_word_valid_out // One-cycle pulse per word
);
   ////////////////////////////////////////////////////////////////////////
   // Constants
   localparam integer PROG_CYC =
      (`MSCL_PROG_MIN_NS + `MSCL_SYS_PERIOD_NS - 1) / `MSCL_SYS_PERIOD_NS;
   localparam [3:0] ST_PROG = 4'h0; // Program request held low
   localparam [3:0] ST_CLEAR = 4'h1; // Clearing memory, init low
   localparam [3:0] ST_WAIT_INIT = 4'h2; // Init released, wait for pin
   localparam [3:0] ST_LOAD = 4'h3; // Shifting own bitstream
   localparam [3:0] ST_FORWARD = 4'h4; // Passing data down the chain
   localparam [3:0] ST_CHECK = 4'h5; // CRC compare
   localparam [3:0] ST_DONE = 4'h6; // Configured
   localparam [3:0] ST_CRC_ERR = 4'h7; // CRC failure, init driven low
   localparam [3:0] ST_OTHER_MODE = 4'h8; // Not master serial, idle

   ////////////////////////////////////////////////////////////////////////
   // Functions
   // One CRC step per serial bit
   function [15:0] crc_step;
      input [15:0] crc;
      input bit_in;
      begin
         crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ bit_in) ? `MSCL_CRC_POLY : 16'h0000);
      end
   endfunction

   // Rate option to half period; unknown options fall to the fastest
   function [7:0] rate_half;
      input [2:0] opt;
      begin
         case (opt)
            3'h0: rate_half = `MSCL_HALF_SLOW;
            3'h1: rate_half = `MSCL_HALF_MID;
            default: rate_half = `MSCL_HALF_FAST;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   wire [2:0] mode_s; // Synchronised mode pins
   wire pud_s; // Synchronised pull-up select
   wire prog_n_s; // Synchronised program request
   wire init_s; // Synchronised init pin
   wire done_s; // Synchronised done pin
   wire data_s; // Synchronised serial data
   wire gclk_rise; // Rising edge event of the generated clock
   wire gclk_fall; // Falling edge event
   wire clk_run; // Divider enable
   reg [3:0] state_r; // Main state
   reg [7:0] prog_cnt_r; // Program-low width, saturating
   reg [15:0] clr_cnt_r; // Clearing timer
   reg [31:0] bit_cnt_r; // Bits taken in current phase
   reg [31:0] shift_r; // Word assembly
   reg [4:0] word_bits_r; // Bits in current word
   reg first_word_r; // First word not yet complete
   reg [15:0] crc_r; // Running CRC
   reg [15:0] crc_rx_r; // CRC carried in the bitstream
   reg [2:0] rate_r; // Selected clock rate option
   reg [2:0] mode_cap_r; // Mode pins captured at init release
   reg pud_cap_r; // Pull-up select captured at init release
   reg last_bit_r; // Most recent bit for forwarding
   reg [31:0] ctrl_r; // Control register
   reg [31:0] own_len_r; // Own bitstream length in bits
   reg [31:0] chain_len_r; // Bits to forward down the chain
   reg [`MSCL_INT_W-1:0] int_stat_r; // Sticky events
   reg [`MSCL_INT_W-1:0] int_mask_r; // Event mask
   reg [`MSCL_INT_W-1:0] int_set; // Events this cycle
   wire crc_en; // CRC check enabled
   wire prog_valid; // Program pulse long enough
   wire [31:0] own_body; // Own bits excluding trailing CRC

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   mscl_sync #(.WIDTH(8), .INIT(8'h9C)) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .async_in({program_request_n_in, init_n_in, done_in, pullup_disable_select_in,
                 serial_data_in, mode_select_in}),
      .sync_out({prog_n_s, init_s, done_s, pud_s, data_s, mode_s})
   );

   // Clock runs only while shifting, never before sampling
   assign clk_run = (state_r == ST_LOAD) || (state_r == ST_FORWARD);

   mscl_clkdiv u_clkdiv (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .run_in(clk_run),
      .half_in(rate_half(rate_r)),
      .gclk_out(config_clock_out),
      .rise_out(gclk_rise),
      .fall_out(gclk_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs
   assign crc_en = ctrl_r[`MSCL_CTRL_CRC_EN];
   assign own_body = own_len_r - 32'd16;
   assign prog_valid = (prog_cnt_r >= PROG_CYC[7:0]);
   assign init_n_out = 1'b0;
   assign done_out = 1'b0;
   // Init low while clearing (resets memory counter) and on CRC failure
   assign init_n_oe_out = (state_r == ST_CLEAR) || (state_r == ST_PROG)
      || (state_r == ST_CRC_ERR);
   // Done low, memory enabled, until a good load ends
   assign done_oe_out = (state_r != ST_DONE);
   assign serial_data_oe_out = (state_r != ST_DONE)
      && (state_r != ST_OTHER_MODE);
   assign user_pins_release_out = (state_r == ST_DONE) && done_s;
   assign pullup_enable_out = (state_r != ST_DONE) && !pud_s;
   assign irq_out = |(int_stat_r & int_mask_r);

   ////////////////////////////////////////////////////////////////////////
   // Program request width; the memory's reload output shares this pin
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prog_cnt_r <= 8'h00;
      end else if (!prog_n_s) begin
         if (!prog_valid) begin
            prog_cnt_r <= prog_cnt_r + 8'h01;
         end
      end else begin
         prog_cnt_r <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequencer
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= ST_CLEAR;
         clr_cnt_r <= 16'h0000;
         bit_cnt_r <= 32'h0000_0000;
         shift_r <= 32'h0000_0000;
         word_bits_r <= 5'h00;
         first_word_r <= 1'b1;
         crc_r <= `MSCL_CRC_INIT;
         crc_rx_r <= 16'h0000;
         rate_r <= 3'h0;
         mode_cap_r <= 3'h0;
         pud_cap_r <= 1'b0;
         last_bit_r <= 1'b0;
         serial_data_out <= 1'b0;
         config_word_out <= 32'h0000_0000;
         config_word_valid_out <= 1'b0;
      end else begin
         config_word_valid_out <= 1'b0;
         if (prog_valid && prog_n_s) begin
            // Valid pulse ended: clear again, indicators reset
            state_r <= ST_CLEAR;
            clr_cnt_r <= 16'h0000;
         end else if (!prog_n_s && prog_valid) begin
            state_r <= ST_PROG;
         end else begin
            case (state_r)
               ST_PROG: begin
                  // Request high again: back to clearing; the valid-pulse branch above takes this first
                  if (prog_n_s) begin
                     state_r <= ST_CLEAR;
                  end
               end
               ST_CLEAR: begin
                  // Clearing only advances while the request is high
                  if (prog_n_s) begin
                     if (clr_cnt_r >= CLEAR_CYCLES - 1) begin
                        state_r <= ST_WAIT_INIT;
                     end else begin
                        clr_cnt_r <= clr_cnt_r + 16'h0001;
                     end
                  end
                  bit_cnt_r <= 32'h0000_0000;
                  word_bits_r <= 5'h00;
                  first_word_r <= 1'b1;
                  crc_r <= `MSCL_CRC_INIT;
                  rate_r <= 3'h0;
               end
               ST_WAIT_INIT: begin
                  // Memory may hold init low until its own reset is done
                  if (init_s) begin
                     mode_cap_r <= mode_s;
                     pud_cap_r <= pud_s;
                     if (mode_s == 3'h0) begin
                        state_r <= ST_LOAD;
                     end else begin
                        state_r <= ST_OTHER_MODE;
                     end
                  end
               end
               ST_LOAD: begin
                  if (gclk_rise) begin
                     // Memory presents one bit per clock
                     last_bit_r <= data_s;
                     shift_r <= {shift_r[30:0], data_s};
                     bit_cnt_r <= bit_cnt_r + 32'd1;
                     if (bit_cnt_r < own_body) begin
                        crc_r <= crc_step(crc_r, data_s);
                     end else begin
                        crc_rx_r <= {crc_rx_r[14:0], data_s};
                     end
                     word_bits_r <= word_bits_r + 5'h01;
                     if (word_bits_r == 5'h1F) begin
                        config_word_out <= {shift_r[30:0], data_s};
                        config_word_valid_out <= 1'b1;
                        first_word_r <= 1'b0;
                        // First word may raise the clock rate
                        if (first_word_r) begin
                           rate_r <= {shift_r[1:0], data_s};
                        end
                     end
                     if (bit_cnt_r >= own_len_r - 32'd1) begin
                        bit_cnt_r <= 32'h0000_0000;
                        if (chain_len_r != 32'h0000_0000) begin
                           state_r <= ST_FORWARD;
                        end else begin
                           state_r <= ST_CHECK;
                        end
                     end
                  end
               end
               ST_FORWARD: begin
                  // Pass data on falling edges after own load
                  // Own last bit is not forwarded: wait for a chain bit
                  if (gclk_fall && (bit_cnt_r != 32'h0000_0000)) begin
                     serial_data_out <= last_bit_r;
                  end
                  if (gclk_rise) begin
                     last_bit_r <= data_s;
                     bit_cnt_r <= bit_cnt_r + 32'd1;
                     if (bit_cnt_r >= chain_len_r) begin
                        state_r <= ST_CHECK;
                     end
                  end
               end
               ST_CHECK: begin
                  if (crc_en && (crc_rx_r != crc_r)) begin
                     state_r <= ST_CRC_ERR;
                  end else begin
                     state_r <= ST_DONE;
                  end
               end
               ST_DONE: state_r <= ST_DONE;
               ST_CRC_ERR: state_r <= ST_CRC_ERR;
               ST_OTHER_MODE: state_r <= ST_OTHER_MODE;
               default: state_r <= ST_CLEAR;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event collection
   always @* begin
      int_set = {`MSCL_INT_W{1'b0}};
      int_set[`MSCL_INT_DONE] = (state_r == ST_CHECK) && !(crc_en && (crc_rx_r != crc_r));
      int_set[`MSCL_INT_CRC_ERR] = (state_r == ST_CHECK) && crc_en && (crc_rx_r != crc_r);
      int_set[`MSCL_INT_MODE_ERR] = (state_r == ST_WAIT_INIT) && init_s && (mode_s != 3'h0);
      int_set[`MSCL_INT_PROG] = prog_valid && prog_n_s;
      int_set[`MSCL_INT_WORD] = config_word_valid_out;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes; a new event wins over a write-one clear
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_r <= `MSCL_RST_CTRL;
         own_len_r <= `MSCL_RST_OWN_LEN;
         chain_len_r <= `MSCL_RST_CHAIN_LEN;
         int_stat_r <= {`MSCL_INT_W{1'b0}};
         int_mask_r <= `MSCL_RST_INT_MASK;
      end else begin
         if (reg_wr_in && reg_addr_in == `MSCL_OFS_INT_STAT) begin
            int_stat_r <= (int_stat_r & ~reg_wdata_in[`MSCL_INT_W-1:0]) | int_set;
         end else begin
            int_stat_r <= int_stat_r | int_set;
         end
         if (reg_wr_in) begin
            case (reg_addr_in)
               `MSCL_OFS_CTRL: ctrl_r <= reg_wdata_in;
               `MSCL_OFS_OWN_LEN: own_len_r <= reg_wdata_in;
               `MSCL_OFS_CHAIN_LEN: chain_len_r <= reg_wdata_in;
               `MSCL_OFS_INT_MASK: int_mask_r <= reg_wdata_in[`MSCL_INT_W-1:0];
               default: ctrl_r <= ctrl_r;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, one cycle after the strobe; unmapped reads zero
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `MSCL_OFS_CTRL: reg_rdata_out <= {31'h0, ctrl_r[`MSCL_CTRL_CRC_EN]};
            `MSCL_OFS_OWN_LEN: reg_rdata_out <= own_len_r;
            `MSCL_OFS_CHAIN_LEN: reg_rdata_out <= chain_len_r;
            `MSCL_OFS_STATUS: reg_rdata_out <= {21'h0, rate_r, pud_cap_r, mode_cap_r, state_r};
            `MSCL_OFS_INT_STAT: reg_rdata_out <= {27'h0, int_stat_r};
            `MSCL_OFS_INT_MASK: reg_rdata_out <= {27'h0, int_mask_r};
            `MSCL_OFS_LAST_WORD: reg_rdata_out <= config_word_out;
            default: reg_rdata_out <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_out <= 32'h0000_0000;
      end
   end
endmodule // mscl_loader

//--- test/mscl_properties.sv
`timescale 1ns/1ps
// Pin-level checker for the loader
module mscl_properties #(
   parameter CLEAR_CYCLES = 64 // Clearing length
) (
   input wire clk_sys_in, // System clock
   input wire rst_b_in, // Reset, active low
   input wire program_request_n_in, // Program request
   input wire init_n_in, // Init pin level
   input wire init_n_oe_out, // Init pulled low
   input wire done_oe_out, // Done pulled low
   input wire config_clock_out, // Configuration clock
   input wire serial_data_out, // Chain data
   input wire serial_data_oe_out, // Chain data enable
   input wire user_pins_release_out, // Pins released
   input wire pullup_enable_out, // Pull-ups on
   input wire config_word_valid_out // Word strobe
);
   reg [4:0] low_cnt_r; // Program low time, saturating
   ////////////////////////////////////////////////////////////////
   // Count low cycles; a repetition of 18 would unroll badly
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) low_cnt_r <= 5'h00;
      else if (program_request_n_in) low_cnt_r <= 5'h00;
      else if (low_cnt_r != 5'h1F) low_cnt_r <= low_cnt_r + 5'h01;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   ////////////////////////////////////////////////////////////////
   clk_after_init_a: assert property ($rose(config_clock_out) |->
      !init_n_oe_out && $past(init_n_in, 2)) else $error("Clock before init release");
   clear_len_a: assert property ($fell(init_n_oe_out) |->
      $past(init_n_oe_out, CLEAR_CYCLES)) else $error("Clearing too short");
   done_order_a: assert property ($fell(done_oe_out) |-> !init_n_oe_out)
      else $error("Done released with init low");
   word_pulse_a: assert property (config_word_valid_out |->
      config_clock_out ##1 !config_word_valid_out) else $error("Word strobe misplaced");
   fwd_edge_a: assert property (serial_data_oe_out && $changed(serial_data_out) |->
      !config_clock_out) else $error("Chain data moved on clock high");
   drive_oe_a: assert property (config_clock_out |-> serial_data_oe_out)
      else $error("Serial output not driven");
   pins_rel_a: assert property (user_pins_release_out |-> !done_oe_out)
      else $error("Pins released early");
   pullup_cfg_a: assert property (pullup_enable_out |-> done_oe_out)
      else $error("Pull-ups after done");
   prog_hold_a: assert property (low_cnt_r == 5'h12 |->
      init_n_oe_out && done_oe_out && !config_clock_out) else $error("Program ignored");
   word_c: cover property (config_word_valid_out);
   done_c: cover property ($fell(done_oe_out));
   prog_c: cover property (low_cnt_r == 5'h12);
endmodule // mscl_properties
bind mscl_loader mscl_properties #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_props (.clk_sys_in,
   .rst_b_in, .program_request_n_in, .init_n_in, .init_n_oe_out, .done_oe_out,
   .config_clock_out, .serial_data_out, .serial_data_oe_out, .user_pins_release_out,
   .pullup_enable_out, .config_word_valid_out);

//--- test/mscl_mem_model.sv
`timescale 1ns/1ps
// Serial configuration memory with an address counter
module mscl_mem_model #(
   parameter DEPTH = 256, // Stored bits
   parameter POR_NS = 2000 // Time until ready
) (
   input wire clk_in, // Configuration clock
   input wire oe_rst_in, // Init line, low clears counter
   input wire ce_n_in, // Done line, low selects
   output reg hold_init_out, // Holds init low while not ready
   output wire data_out // Serial data
);
   reg bits_r [0:DEPTH-1]; // Bitstream, filled by the bench
   integer addr_r = 0; // Address counter
   reg last_r = 1'b0; // Last bit shown
   // Keep the loader in init until power-on reset is over
   initial begin
      hold_init_out = 1'b1;
      #(POR_NS);
      hold_init_out = 1'b0;
   end
   // One bit per rising edge while selected
   always @(posedge clk_in or negedge oe_rst_in) begin
      if (!oe_rst_in) begin
         addr_r <= 0;
      end else if (!ce_n_in) begin
         last_r <= bits_r[addr_r];
         addr_r <= (addr_r + 1) % DEPTH;
      end
   end
   // Deselected: inverse of the last bit, never a stale copy
   assign data_out = (oe_rst_in && !ce_n_in) ? bits_r[addr_r] : ~last_r;
endmodule // mscl_mem_model

//--- test/tb_master_serial_config_load.sv
`timescale 1ns/1ps
`include "mscl_regs.vh"
module tb_master_serial_config_load;
   reg clk_sys_in = 1'b0; // System clock
   reg rst_b_in = 1'b0; // Reset
   reg [7:0] reg_addr_in = 8'h00;
   reg [31:0] reg_wdata_in = 32'h0;
   reg reg_wr_in = 1'b0;
   reg reg_rd_in = 1'b0;
   reg [2:0] mode_select_in = 3'h7; // Other mode first: no stray load
   reg pullup_disable_select_in = 1'b1;
   reg program_request_n_in = 1'b1;
   wire [31:0] reg_rdata_out, config_word_out;
   wire irq_out, init_n_oe_out, done_oe_out, config_clock_out, serial_data_out;
   wire serial_data_oe_out, user_pins_release_out, pullup_enable_out, config_word_valid_out;
   wire hold_init, serial_data_in;
   wire init_n_in = !(init_n_oe_out | hold_init); // Open drain, pulled up
   wire done_in = !done_oe_out; // Open drain, pulled up
   integer bad_count = 0, tests_run = 0, seed = 32'hf2e6, k;
   reg [31:0] exp_q [$]; // Expected words
   mscl_loader #(.CLEAR_CYCLES(8)) DUT (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out, .mode_select_in,
      .pullup_disable_select_in, .program_request_n_in, .init_n_in, .init_n_out(),
      .init_n_oe_out, .done_in, .done_out(), .done_oe_out, .config_clock_out, .serial_data_in,
      .serial_data_out, .serial_data_oe_out, .user_pins_release_out, .pullup_enable_out,
      .config_word_out, .config_word_valid_out);
   mscl_mem_model mem (.clk_in(config_clock_out), .oe_rst_in(init_n_in), .ce_n_in(done_in),
      .hold_init_out(hold_init), .data_out(serial_data_in));
   always #20 clk_sys_in = ~clk_sys_in;
   ////////////////////////////////////////////////////////////////
   task check(input [31:0] seen, input [31:0] exp); begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   end endtask
   task wr_reg(input [7:0] a, input [31:0] d); begin
      @(posedge clk_sys_in);
      reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   end endtask
   // Read data stand only in the cycle after the strobe
   task rd_chk(input [7:0] a, input [31:0] exp); begin
      @(posedge clk_sys_in);
      reg_addr_in <= a; reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 check(reg_rdata_out, exp);
   end endtask
   task gap; begin
      repeat (3) @(posedge clk_sys_in);
      #1;
   end endtask
   task pulse(input integer n); begin
      @(posedge clk_sys_in);
      program_request_n_in <= 1'b0;
      repeat (n) @(posedge clk_sys_in);
      program_request_n_in <= 1'b1;
   end endtask
   // Bitstream: 48 data bits, CRC-16 MSB first, then chain data
   task load(input [2:0] rate, input bad); reg [63:0] own; reg [15:0] crc; begin
      own = {$random(seed), $random(seed)};
      own[34:32] = rate;
      crc = 16'hFFFF;
      for (k = 63; k >= 16; k = k - 1)
         crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ own[k]) ? 16'h1021 : 16'h0000);
      own[15:0] = crc ^ {15'h0, bad};
      for (k = 0; k < 256; k = k + 1) mem.bits_r[k] = (k < 64) ? own[63-k] : ^$random(seed);
      exp_q.delete();
      exp_q.push_back(own[63:32]);
      exp_q.push_back(own[31:0]);
      wr_reg(`MSCL_OFS_INT_STAT, 32'h1F);
      pulse(20);
      for (k = 0; k < 20000 && irq_out !== 1'b1; k = k + 1) @(posedge clk_sys_in);
      check(irq_out, 1'b1);
      gap;
   end endtask
   task wrap_up; begin
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   end endtask
   ////////////////////////////////////////////////////////////////
   // Each word strobe against the bench's own stream
   always @(posedge clk_sys_in) begin
      if (config_word_valid_out === 1'b1) check(config_word_out, exp_q.pop_front());
   end
   initial begin
      #2_400_000;
      bad_count = bad_count + 1;
      wrap_up;
   end
   initial begin
      repeat (12) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      rd_chk(`MSCL_OFS_CTRL, `MSCL_RST_CTRL);
      rd_chk(`MSCL_OFS_OWN_LEN, `MSCL_RST_OWN_LEN);
      rd_chk(`MSCL_OFS_CHAIN_LEN, `MSCL_RST_CHAIN_LEN);
      rd_chk(8'h1C, 32'h0);
      for (k = 0; k < 200 && init_n_in !== 1'b1; k = k + 1) @(posedge clk_sys_in);
      repeat (40) @(posedge clk_sys_in);
      check(config_clock_out, 1'b0);
      rd_chk(`MSCL_OFS_STATUS, 32'hF8);
      rd_chk(`MSCL_OFS_INT_STAT, 32'h04);
      check(irq_out, 1'b0);
      wr_reg(`MSCL_OFS_INT_MASK, 32'h04);
      gap;
      check(irq_out, 1'b1);
      wr_reg(`MSCL_OFS_INT_STAT, 32'h04);
      gap;
      check(irq_out, 1'b0);
      wr_reg(`MSCL_OFS_OWN_LEN, 32'h40);
      wr_reg(`MSCL_OFS_CHAIN_LEN, 32'h1E);
      wr_reg(`MSCL_OFS_INT_MASK, 32'h03);
      mode_select_in <= 3'h0;
      load(3'h2, 1'b0);
      rd_chk(`MSCL_OFS_STATUS, 32'h286);
      check(done_in, 1'b1);
      check(user_pins_release_out, 1'b1);
      check(pullup_enable_out, 1'b0);
      check(serial_data_out, mem.bits_r[93]);
      rd_chk(`MSCL_OFS_INT_STAT, 32'h19);
      check(exp_q.size(), 0);
      pulse(10);
      gap;
      check(done_in, 1'b1);
      pullup_disable_select_in <= 1'b0;
      load(3'h0, 1'b1);
      rd_chk(`MSCL_OFS_STATUS, 32'h07);
      check(init_n_in, 1'b0);
      check(done_in, 1'b0);
      check(pullup_enable_out, 1'b1);
      rd_chk(`MSCL_OFS_INT_STAT, 32'h1A);
      check(irq_out, 1'b1);
      wrap_up;
   end
endmodule // tb_master_serial_config_load
